// file: src/filter_sequencer.v
// Calibration and initialization requests of the baseband filter
`default_nettype none
`include "rx_config_defs.vh"
module filter_sequencer (
    input wire sys_clk,
    input wire sys_rst,
    input wire wide_force,
    input wire [1:0] width_code,
    input wire [1:0] cal_policy,
    input wire [1:0] init_policy,
    input wire cal_force_wr,
    input wire init_force_wr,
    output reg cal_start_q,
    output reg init_start_q
);
    reg started_q;
    reg [2:0] prev_width_q;
    wire [2:0] width_now;
    wire changed;
    wire cal_d;
    wire init_d;

    // Forced widest mode counts as a bandwidth change too
    assign width_now = {wide_force, width_code};
    assign changed = started_q && (width_now != prev_width_q);
    // Forced calibration requests come already masked by the widest bit being written
    assign cal_d = cal_force_wr || (!wide_force &&
        ((!started_q && cal_policy == `POLICY_STARTUP) ||
        (changed && cal_policy == `POLICY_ON_CHANGE)));
    assign init_d = init_force_wr ||
        (!started_q && init_policy == `POLICY_STARTUP) ||
        (changed && init_policy == `POLICY_ON_CHANGE);

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            started_q <= 1'b0;
            prev_width_q <= 3'h0;
            cal_start_q <= 1'b0;
            init_start_q <= 1'b0;
        end else begin
            started_q <= 1'b1;
            prev_width_q <= width_now;
            cal_start_q <= cal_d;
            init_start_q <= init_d;
        end
    end
endmodule // filter_sequencer
`default_nettype wire

// file: src/pattern_matcher.v
// Pattern comparator over the demodulated bit stream
`default_nettype none
`include "rx_config_defs.vh"
module pattern_matcher (
    input wire sys_clk,
    input wire sys_rst,
    input wire enable,
    input wire [1:0] size_code,
    input wire [1:0] tolerance,
    input wire [31:0] pattern,
    input wire bit_in,
    input wire bit_valid,
    output reg match_q
);
    reg [31:0] hist_q;
    reg [5:0] fill_q;
    reg valid_q;
    reg [5:0] errors;
    wire [5:0] len;
    wire [31:0] aligned;
    wire [31:0] miss;
    integer k;

    assign len = {1'b0, size_code, 3'h0} + 6'h08;
    // Pattern in use sits at the top; the newest bit meets its LSB
    assign aligned = pattern >> (6'h20 - len);

    genvar i;
    generate
        for (i = 0; i < 32; i = i + 1) begin : cmp
            localparam [31:0] IDX = i;
            assign miss[i] = ({26'h000_0000, len} > IDX) &&
                (hist_q[i] ^ aligned[i]);
        end
    endgenerate

    always @* begin
        errors = 6'h00;
        for (k = 0; k < 32; k = k + 1) begin
            errors = errors + {5'h00, miss[k]};
        end
    end

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            hist_q <= 32'h0000_0000;
            fill_q <= 6'h00;
            valid_q <= 1'b0;
            match_q <= 1'b0;
        end else begin
            valid_q <= bit_valid;
            if (bit_valid) begin
                hist_q <= {hist_q[30:0], bit_in};
                if (fill_q != `FULL_PATTERN) begin
                    fill_q <= fill_q + 6'h01;
                end
            end
            match_q <= enable && valid_q && (fill_q >= len) &&
                (errors <= {4'h0, tolerance});
        end
    end
endmodule // pattern_matcher
`default_nettype wire

// file: src/receiver_config_regs.v
// Receiver configuration register bank with its control sequencing
// How it works
// - Bandwidth code picks 10, 20, 40, 200 kHz
// - Widest bit overrides code, suppresses calibration
// - Calibration policy: start-up, never, on change
// - Every write of 11 with widest bit clear forces one calibration
// - Init policy: start-up, on change, forced
// - Read-only strength level from three thresholds
// - Frequency error meter on or off
// - Writing zero starts correction; reads one running
// - Result bit: zero success, one failure
// - Bypass bit blocks correction onto oscillator
// - Overflow bit shows integrator too large
// - Writing one to overflow resets integrator
// - Mode bit: sensitivity or linearity
// - Pattern enable and length 8 to 32
// - Comparator tolerates zero to three mismatches
// - Frequency error readable as two bytes
// - First bit meets pattern MSB, last the lowest pattern bit in use (LSB only at length 32)
`default_nettype none
`include "rx_config_defs.vh"
module receiver_config_regs (
    input wire sys_clk,
    input wire sys_rst,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire strength_threshold_one,
    input wire strength_threshold_two,
    input wire strength_threshold_three,
    input wire [15:0] freq_error_value,
    input wire freq_correct_done,
    input wire freq_correct_failed,
    input wire freq_integrator_overflow,
    input wire [31:0] reference_pattern,
    input wire demod_bit,
    input wire demod_bit_valid,
    output reg bitsync_off,
    output reg [1:0] baseband_width_code,
    output reg widest_filter_force,
    output wire filter_cal_start,
    output wire filter_init_start,
    output reg strength_meter_on,
    output reg strength_range_select,
    output reg freq_error_meter_on,
    output reg freq_correct_start,
    output reg freq_correct_bypass,
    output reg integrator_reset,
    output reg quadrature_amp_on,
    output reg linearity_mode,
    output reg pattern_enable,
    output reg [1:0] pattern_size_code,
    output reg [1:0] pattern_tolerance,
    output wire pattern_match
);
    reg [1:0] filter_calibration_policy_q;
    reg [1:0] filter_init_policy_q;
    reg [1:0] strength_level_code_q;
    reg freq_correct_run_q;
    reg freq_correct_result_q;
    reg freq_integrator_overflow_q;
    reg [15:0] freq_error_q;
    reg [7:0] freq_error_low_snap_q;
    reg [7:0] rdata_d;
    reg [1:0] level_d;
    wire wr_filter;
    wire wr_level;
    wire wr_pattern;
    wire rd_high;
    wire cal_force_wr;
    wire init_force_wr;
    wire start_req;

    assign wr_filter = reg_wr && (reg_addr == `ADDR_FILTER_CTRL);
    assign wr_level = reg_wr && (reg_addr == `ADDR_LEVEL_CORR);
    assign wr_pattern = reg_wr && (reg_addr == `ADDR_PATTERN_MODE);
    assign rd_high = reg_rd && (reg_addr == `ADDR_FERR_HIGH);

    // Decoded from the write itself, so 11 over 11 still counts
    // Widest bit of the same write decides, not the old one
    assign cal_force_wr = wr_filter && !reg_wdata[`BIT_WIDE] &&
        (reg_wdata[`CAL_HI:`CAL_LO] == `POLICY_FORCE);
    assign init_force_wr = wr_filter &&
        (reg_wdata[`INIT_HI:`INIT_LO] == `POLICY_FORCE);
    assign start_req = wr_level && !reg_wdata[`BIT_CORR_RUN];

    // Filter control byte
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            bitsync_off <= 1'b0;
            baseband_width_code <= 2'h0;
            widest_filter_force <= 1'b0;
            filter_calibration_policy_q <= 2'h0;
            filter_init_policy_q <= 2'h0;
        end else if (wr_filter) begin
            bitsync_off <= reg_wdata[`BIT_BITSYNC_OFF];
            baseband_width_code <= reg_wdata[`BW_HI:`BW_LO];
            widest_filter_force <= reg_wdata[`BIT_WIDE];
            filter_calibration_policy_q <= reg_wdata[`CAL_HI:`CAL_LO];
            filter_init_policy_q <= reg_wdata[`INIT_HI:`INIT_LO];
        end
    end

    // Level and correction byte, software-owned fields
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            strength_meter_on <= 1'b0;
            strength_range_select <= 1'b0;
            freq_error_meter_on <= 1'b0;
            freq_correct_bypass <= 1'b0;
        end else if (wr_level) begin
            strength_meter_on <= reg_wdata[`BIT_STRENGTH_ON];
            strength_range_select <= reg_wdata[`BIT_STRENGTH_RANGE];
            freq_error_meter_on <= reg_wdata[`BIT_FEI_ON];
            freq_correct_bypass <= reg_wdata[`BIT_CORR_BYPASS];
        end
    end

    // Correction run and result; a start beside a finish wins the run bit, the finish wins the result bit
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            freq_correct_run_q <= 1'b0;
            freq_correct_start <= 1'b0;
            freq_correct_result_q <= 1'b0;
        end else begin
            freq_correct_start <= start_req;
            if (start_req) begin
                freq_correct_run_q <= 1'b1;
            end else if (freq_correct_done) begin
                freq_correct_run_q <= 1'b0;
            end
            if (freq_correct_done) begin
                freq_correct_result_q <= freq_correct_failed;
            end else if (wr_level) begin
                freq_correct_result_q <= reg_wdata[`BIT_CORR_RESULT];
            end
        end
    end

    // Strength level from the three threshold comparators
    always @* begin
        if (strength_threshold_three) begin
            level_d = 2'h3;
        end else if (strength_threshold_two) begin
            level_d = 2'h2;
        end else if (strength_threshold_one) begin
            level_d = 2'h1;
        end else begin
            level_d = 2'h0;
        end
    end

    // Status sampling; bus writes never reach these flops
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            strength_level_code_q <= 2'h0;
            freq_integrator_overflow_q <= 1'b0;
            freq_error_q <= `RST_FERR;
        end else begin
            strength_level_code_q <= level_d;
            freq_integrator_overflow_q <= freq_integrator_overflow;
            freq_error_q <= freq_error_value;
        end
    end

    // Low byte frozen on a high-byte read so both halves match
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            freq_error_low_snap_q <= 8'h00;
        end else if (rd_high) begin
            freq_error_low_snap_q <= freq_error_q[7:0];
        end
    end

    // Pattern and mode byte
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            integrator_reset <= 1'b0;
            quadrature_amp_on <= 1'b0;
            linearity_mode <= 1'b0;
            pattern_enable <= 1'b0;
            pattern_size_code <= 2'h0;
            pattern_tolerance <= 2'h0;
        end else begin
            integrator_reset <= wr_pattern &&
                reg_wdata[`BIT_OVERFLOW];
            if (wr_pattern) begin
                quadrature_amp_on <= reg_wdata[`BIT_QUAD_AMP];
                linearity_mode <= reg_wdata[`BIT_LIN_MODE];
                pattern_enable <= reg_wdata[`BIT_PAT_EN];
                pattern_size_code <= reg_wdata[`PSIZE_HI:`PSIZE_LO];
                pattern_tolerance <= reg_wdata[`PTOL_HI:`PTOL_LO];
            end
        end
    end

    // Read mux; unmapped addresses read as zero
    always @* begin
        rdata_d = `READ_IDLE;
        case (reg_addr)
            `ADDR_FILTER_CTRL: begin
                rdata_d = {bitsync_off, baseband_width_code,
                    widest_filter_force, filter_calibration_policy_q,
                    filter_init_policy_q};
            end
            `ADDR_LEVEL_CORR: begin
                rdata_d = {strength_meter_on, strength_range_select,
                    strength_level_code_q, freq_error_meter_on,
                    freq_correct_run_q, freq_correct_result_q,
                    freq_correct_bypass};
            end
            `ADDR_PATTERN_MODE: begin
                rdata_d = {freq_integrator_overflow_q, quadrature_amp_on,
                    linearity_mode, pattern_enable, pattern_size_code,
                    pattern_tolerance};
            end
            `ADDR_FERR_HIGH: begin
                rdata_d = freq_error_q[15:8];
            end
            `ADDR_FERR_LOW: begin
                rdata_d = freq_error_low_snap_q;
            end
            default: begin
                rdata_d = `READ_IDLE;
            end
        endcase
    end

    // Data stand in the cycle after the read strobe only
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            reg_rdata <= `READ_IDLE;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end else begin
            reg_rdata <= `READ_IDLE;
        end
    end

    filter_sequencer seq (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .wide_force(widest_filter_force),
        .width_code(baseband_width_code),
        .cal_policy(filter_calibration_policy_q),
        .init_policy(filter_init_policy_q),
        .cal_force_wr(cal_force_wr),
        .init_force_wr(init_force_wr),
        .cal_start_q(filter_cal_start),
        .init_start_q(filter_init_start)
    );

    pattern_matcher matcher (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .enable(pattern_enable),
        .size_code(pattern_size_code),
        .tolerance(pattern_tolerance),
        .pattern(reference_pattern),
        .bit_in(demod_bit),
        .bit_valid(demod_bit_valid),
        .match_q(pattern_match)
    );
endmodule // receiver_config_regs
`default_nettype wire

// file: src/rx_config_defs.vh
// Offsets, field positions, codes and reset values of the receiver bank
`ifndef RX_CONFIG_DEFS_VH
`define RX_CONFIG_DEFS_VH
`define ADDR_FILTER_CTRL 8'h08
`define ADDR_LEVEL_CORR 8'h09
`define ADDR_PATTERN_MODE 8'h0a
`define ADDR_FERR_HIGH 8'h0b
`define ADDR_FERR_LOW 8'h0c
`define BIT_BITSYNC_OFF 7
`define BW_HI 6
`define BW_LO 5
`define BIT_WIDE 4
`define CAL_HI 3
`define CAL_LO 2
`define INIT_HI 1
`define INIT_LO 0
`define BIT_STRENGTH_ON 7
`define BIT_STRENGTH_RANGE 6
`define LEVEL_HI 5
`define LEVEL_LO 4
`define BIT_FEI_ON 3
`define BIT_CORR_RUN 2
`define BIT_CORR_RESULT 1
`define BIT_CORR_BYPASS 0
`define BIT_OVERFLOW 7
`define BIT_QUAD_AMP 6
`define BIT_LIN_MODE 5
`define BIT_PAT_EN 4
`define PSIZE_HI 3
`define PSIZE_LO 2
`define PTOL_HI 1
`define PTOL_LO 0
`define POLICY_STARTUP 2'h0
`define POLICY_NEVER 2'h1
`define POLICY_ON_CHANGE 2'h2
`define POLICY_FORCE 2'h3
`define RST_FILTER_CTRL 8'h00
`define RST_LEVEL_CORR 8'h00
`define RST_PATTERN_MODE 8'h00
`define RST_FERR 16'h0000
`define READ_IDLE 8'h00
`define FULL_PATTERN 6'h20
`endif

// file: test/receiver_config_regs_tb.sv
// Self-checking bench of the receiver configuration bank
`default_nettype none
module receiver_config_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd_q;
    logic reg_wr = 1'b0, reg_rd = 1'b0, demod_bit = 1'b0;
    logic freq_correct_done = 1'b0, freq_correct_failed = 1'b0;
    logic strength_threshold_one = 1'b0, strength_threshold_two = 1'b0;
    logic strength_threshold_three = 1'b0, freq_integrator_overflow = 1'b0;
    logic demod_bit_valid = 1'b0;
    logic [15:0] freq_error_value = 16'h0000;
    logic [31:0] reference_pattern = 32'h0000_0000;
    logic bitsync_off, widest_filter_force, filter_cal_start;
    logic filter_init_start, strength_meter_on, strength_range_select;
    logic freq_error_meter_on, freq_correct_start, freq_correct_bypass;
    logic integrator_reset, quadrature_amp_on, linearity_mode;
    logic pattern_enable, pattern_match;
    logic [1:0] baseband_width_code, pattern_size_code, pattern_tolerance;
    logic [7:0] pa[3] = '{8'h0a, 8'h05, 8'h08};
    logic [7:0] pb[3] = '{8'h2a, 8'h45, 8'h18};
    logic [7:0] pe[3] = '{8'h03, 8'h00, 8'h00};
    logic [7:0] fc[3] = '{8'h0c, 8'h0c, 8'h1c};
    logic [1:0] pt[5] = '{2'h0, 2'h0, 2'h1, 2'h3, 2'h2};
    int pf[5] = '{0, 1, 1, 3, 3};
    int fails = 0, checked = 0;
    receiver_config_regs dut_u (.sys_clk, .sys_rst, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .strength_threshold_one,
        .strength_threshold_two, .strength_threshold_three,
        .freq_error_value, .freq_correct_done, .freq_correct_failed,
        .freq_integrator_overflow, .reference_pattern, .demod_bit,
        .demod_bit_valid, .bitsync_off, .baseband_width_code,
        .widest_filter_force, .filter_cal_start, .filter_init_start,
        .strength_meter_on, .strength_range_select, .freq_error_meter_on,
        .freq_correct_start, .freq_correct_bypass, .integrator_reset,
        .quadrature_amp_on, .linearity_mode, .pattern_enable,
        .pattern_size_code, .pattern_tolerance, .pattern_match);
    always #25 sys_clk = ~sys_clk;
    function automatic logic [1:0] level(input logic [2:0] t);
        return t[2] ? 2'h3 : t[1] ? 2'h2 : t[0] ? 2'h1 : 2'h0;
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Returns just after the edge ending the strobe cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rd_q = reg_rdata;
    endtask
    task automatic give_verdict;
        if (fails == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #500000;
        fails++;
        give_verdict;
    end
    initial begin
        logic [7:0] d, e;
        logic [15:0] v;
        logic [31:0] r;
        void'($urandom(65750));
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        #1 chk({filter_cal_start, filter_init_start}, 8'h03);
        repeat (8) begin
            d = 8'($urandom);
            e = 8'($urandom);
            freq_integrator_overflow <= 1'($urandom);
            wr(8'h08, d);
            chk({bitsync_off, baseband_width_code, widest_filter_force, 4'h0},
                d & 8'hf0);
            chk({filter_cal_start, filter_init_start},
                {d[3:2] == 2'h3 && !d[4], d[1:0] == 2'h3});
            rd(8'h08);
            chk(rd_q, d);
            wr(8'h0a, e);
            chk({integrator_reset, quadrature_amp_on, linearity_mode,
                pattern_enable, pattern_size_code, pattern_tolerance},
                e);
            rd(8'h0a);
            chk(rd_q, {freq_integrator_overflow, e[6:0]});
        end
        // Width change: the pulse lands one cycle after the write
        for (int i = 0; i < 3; i++) begin
            wr(8'h08, pa[i]);
            wr(8'h08, pb[i]);
            @(posedge sys_clk);
            #1 chk({filter_cal_start, filter_init_start}, pe[i]);
        end
        foreach (fc[i]) begin
            wr(8'h08, fc[i]);
            chk(filter_cal_start, !fc[i][4]);
        end
        wr(8'h09, 8'hc9);
        chk({strength_meter_on, strength_range_select, 2'h0,
            freq_error_meter_on, freq_correct_start, 1'b0,
            freq_correct_bypass}, 8'hcd);
        rd(8'h09);
        chk(rd_q, 8'hcd);
        @(posedge sys_clk);
        freq_correct_done <= 1'b1;
        freq_correct_failed <= 1'b1;
        @(posedge sys_clk);
        freq_correct_done <= 1'b0;
        rd(8'h09);
        chk(rd_q, 8'hcb);
        wr(8'h09, 8'h34);
        chk(freq_correct_start, 8'h00);
        for (int i = 0; i < 4; i++) begin
            r = 32'h7 >> (3 - i);
            {strength_threshold_three, strength_threshold_two,
                strength_threshold_one} <= r[2:0];
            rd(8'h09);
            chk(rd_q, {2'h0, level(r[2:0]), 4'h0});
        end
        v = 16'($urandom);
        freq_error_value <= v;
        repeat (2) @(posedge sys_clk);
        rd(8'h0b);
        chk(rd_q, v[15:8]);
        freq_error_value <= ~v;
        wr(8'h0c, 8'h5a);
        rd(8'h0c);
        chk(rd_q, v[7:0]);
        rd(8'h0b);
        chk(rd_q, ~v[15:8]);
        rd(8'h3f);
        chk(rd_q, 8'h00);
        // Eight-bit pattern, last bits flipped against the tolerance
        r = $urandom;
        reference_pattern <= r;
        foreach (pt[i]) begin
            wr(8'h0a, {6'h04, pt[i]});
            for (int b = 7; b >= 0; b--) begin
                @(posedge sys_clk);
                demod_bit <= r[24 + b] ^ (b < pf[i]);
                demod_bit_valid <= 1'b1;
            end
            @(posedge sys_clk);
            demod_bit_valid <= 1'b0;
            @(posedge sys_clk);
            #1 chk(pattern_match, pf[i] <= int'(pt[i]));
        end
        // Full 32-bit pattern: first bit flipped, then an exact copy
        wr(8'h0a, 8'h1c);
        for (int p = 0; p < 2; p++) begin
            for (int b = 31; b >= 0; b--) begin
                @(posedge sys_clk);
                demod_bit <= r[b] ^ (p == 0 && b == 31);
                demod_bit_valid <= 1'b1;
            end
            @(posedge sys_clk);
            demod_bit_valid <= 1'b0;
            @(posedge sys_clk);
            #1 chk(pattern_match, 8'(p));
        end
        give_verdict;
    end
endmodule // receiver_config_regs_tb
`default_nettype wire

// file: test/rx_config_checker.sv
// Assertion checker for the receiver configuration bank
`default_nettype none
module rx_config_checker (
    input wire sys_clk,
    input wire sys_rst,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire widest_filter_force,
    input wire filter_cal_start,
    input wire freq_correct_start,
    input wire freq_correct_bypass,
    input wire integrator_reset,
    input wire quadrature_amp_on,
    input wire linearity_mode,
    input wire pattern_enable,
    input wire [1:0] pattern_size_code,
    input wire [1:0] pattern_tolerance
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    wire w8 = reg_wr && reg_addr == 8'h08;
    wire w9 = reg_wr && reg_addr == 8'h09;
    wire corr_wr = w9 && !reg_wdata[2];
    wire ovf_wr = reg_wr && reg_addr == 8'h0a && reg_wdata[7];
    wire [6:0] mode_bits = {quadrature_amp_on, linearity_mode,
        pattern_enable, pattern_size_code, pattern_tolerance};
    rdata_idle_a: assert property (
        !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("stale read data");
    cal_force_a: assert property (
        w8 && reg_wdata[3:2] == 2'h3 && !reg_wdata[4] |=> filter_cal_start)
        else $error("forced calibration missing");
    wide_nocal_a: assert property (
        widest_filter_force && $past(widest_filter_force) |-> !filter_cal_start)
        else $error("calibration while widest forced");
    corr_start_a: assert property (corr_wr |=> freq_correct_start)
        else $error("correction start missing");
    corr_cause_a: assert property (
        freq_correct_start |-> $past(corr_wr)) else $error("stray start");
    bypass_write_a: assert property (
        w9 |=> freq_correct_bypass == $past(reg_wdata[0]))
        else $error("bypass bit not stored");
    integ_reset_a: assert property (
        integrator_reset |-> $past(ovf_wr)) else $error("stray reset");
    mode_read_a: assert property (
        reg_rd && reg_addr == 8'h0a |=> reg_rdata[6:0] == $past(mode_bits))
        else $error("mode byte readback wrong");
    unmapped_read_a: assert property (
        reg_rd && (reg_addr < 8'h08 || reg_addr > 8'h0c) |=>
        reg_rdata == 8'h00) else $error("unmapped read not zero");
endmodule // rx_config_checker
bind receiver_config_regs rx_config_checker chk_u (.sys_clk, .sys_rst,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .widest_filter_force,
    .filter_cal_start, .freq_correct_start, .freq_correct_bypass,
    .integrator_reset, .quadrature_amp_on, .linearity_mode, .pattern_enable,
    .pattern_size_code, .pattern_tolerance);
`default_nettype wire
